// >>> rtl/msr_control.sv
// Module select gating and full reset sequencing for a pluggable module's management side.
//
// Functional notes
// - While select is low the block passes management bus commands and answers.
// - While select is high all management bus traffic is ignored, own address included.
// - An undriven select pin reads as deselected because of the internal pull-up.
// - An undriven reset pin reads as inactive high because of the internal pull-up.
// - A reset low for longer than the least pulse time restores every user setting to default.
// - The initialization interval is timed from the rising edge that ends the reset low.
// - At the end of reset the attention output goes low with data-not-ready cleared.
// - After power-up the same completion attention is posted with no reset pulse applied.
// - The attention output goes low to signal an operational fault or a critical status.
module msr_control #(
    parameter int unsigned RESET_MIN_CYCLES = msr_pkg::RESET_MIN_CYCLES,
    parameter int unsigned INIT_CYCLES = msr_pkg::INIT_CYCLES,
    parameter int unsigned FAULT_W = msr_pkg::FAULT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    // Pin level and drive enable as seen from the host side; pull-up resolved here.
    input wire logic module_select_pin_n,
    input wire logic module_select_pin_oe,
    input wire logic module_reset_pin_n,
    input wire logic module_reset_pin_oe,
    // Serial bus transaction strobes from the management bus engine.
    input wire logic bus_cmd_valid,
    output logic bus_cmd_accept,
    output logic bus_answer_en,
    // Settings written over the bus and held here.
    input wire logic settings_we,
    input wire logic [msr_pkg::SETTINGS_W-1:0] settings_wdata,
    output logic [msr_pkg::SETTINGS_W-1:0] settings,
    // Fault and critical status events; flag clear after host read.
    input wire logic [FAULT_W-1:0] fault_event,
    input wire logic flags_read,
    output logic [FAULT_W-1:0] fault_flags,
    output logic data_not_ready,
    output logic init_busy,
    // Open-drain attention pin: output level and drive enable.
    output logic attention_out_n,
    output logic attention_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin resolution with internal pull-ups.
    wire logic module_select_n = module_select_pin_oe ? module_select_pin_n : 1'b1;
    wire logic module_reset_n = module_reset_pin_oe ? module_reset_pin_n : 1'b1;
    wire logic selected = !module_select_n;

    ////////////////////////////////////////////////////////////////////////////
    // Reset low time measurement.
    logic low_long;
    msr_low_timer #(
        .LIMIT(RESET_MIN_CYCLES)
    ) u_low_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .low_level(!module_reset_n),
        .long_enough(low_long)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    localparam int unsigned IW = $clog2(INIT_CYCLES + 1);
    localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES - 1);
    msr_pkg::msr_state_t state_q;
    msr_pkg::msr_state_t state_d;
    logic [IW-1:0] init_cnt_q;
    logic [IW-1:0] init_cnt_d;
    logic [msr_pkg::SETTINGS_W-1:0] settings_q;
    logic [msr_pkg::SETTINGS_W-1:0] settings_d;
    logic dnr_q;
    logic dnr_d;
    logic done_flag_q;
    logic done_flag_d;
    logic [FAULT_W-1:0] flags_q;
    logic [FAULT_W-1:0] flags_d;

    // The pin must still be low when the limit is seen, so a pulse of exactly the least length is ignored.
    wire logic full_reset = low_long && !module_reset_n;
    wire logic release_edge = (state_q == msr_pkg::MSR_HOLD) && module_reset_n;
    wire logic init_end = (state_q == msr_pkg::MSR_INIT) && (init_cnt_q == INIT_LAST);
    wire logic running = (state_q == msr_pkg::MSR_RUN);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            msr_pkg::MSR_RUN: begin
                if (full_reset) begin
                    state_d = msr_pkg::MSR_HOLD;
                end
            end
            msr_pkg::MSR_HOLD: begin
                if (release_edge) begin
                    state_d = msr_pkg::MSR_INIT;
                end
            end
            msr_pkg::MSR_INIT: begin
                if (full_reset) begin
                    state_d = msr_pkg::MSR_HOLD;
                end else if (init_end) begin
                    state_d = msr_pkg::MSR_RUN;
                end
            end
        endcase
    end

    assign init_cnt_d = (state_q == msr_pkg::MSR_INIT) ? init_cnt_q + IW'(1) : '0;
    // Settings return to defaults for the whole reset and initialization time.
    assign settings_d = !running ? msr_pkg::SETTINGS_RESET
                      : (settings_we && selected) ? settings_wdata : settings_q;
    // Follows the next state so data-not-ready rises in the same cycle as the busy indication.
    assign dnr_d = (state_d != msr_pkg::MSR_RUN);
    // Completion attention stays posted until the host reads the flags; a new completion wins.
    assign done_flag_d = init_end ? 1'b1 : (flags_read && selected ? 1'b0 : done_flag_q);
    // Fault events win over a clear in the same cycle so none is lost.
    assign flags_d = !running ? '0
                   : (fault_event | ((flags_read && selected) ? '0 : flags_q));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Power-up enters initialization directly, so completion posts unprompted.
            state_q <= msr_pkg::MSR_INIT;
            init_cnt_q <= '0;
            settings_q <= msr_pkg::SETTINGS_RESET;
            dnr_q <= 1'b1;
            done_flag_q <= 1'b0;
            flags_q <= '0;
        end else begin
            state_q <= state_d;
            init_cnt_q <= init_cnt_d;
            settings_q <= settings_d;
            dnr_q <= dnr_d;
            done_flag_q <= done_flag_d;
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    // Commands during reset are still taken so the host can poll data-not-ready.
    assign bus_cmd_accept = bus_cmd_valid && selected;
    assign bus_answer_en = selected;
    assign settings = settings_q;
    assign fault_flags = flags_q;
    assign data_not_ready = dnr_q;
    assign init_busy = !running;
    wire logic attention = done_flag_q || (|flags_q);
    // Open drain: only ever drive low.
    assign attention_out_n = 1'b0;
    assign attention_oe = attention;
endmodule // msr_control

// >>> rtl/msr_low_timer.sv
// Counter that measures how long the reset input has been held low.
module msr_low_timer #(
    parameter int unsigned LIMIT = 1000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic low_level,
    output logic long_enough
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    wire logic at_limit = (count_q == LIMIT_C);

    // Saturating so a very long hold never wraps back below the limit.
    assign count_d = !low_level ? '0 : (at_limit ? count_q : count_q + CW'(1));
    assign long_enough = at_limit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // msr_low_timer

// >>> rtl/msr_pkg.sv
// Constants shared by the module select and reset control block.
package msr_pkg;
    // Clock period of sys_clk in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Least low time on the reset input that starts a full reset, in microseconds.
    localparam int unsigned RESET_MIN_US = 10;
    localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Initialization interval after reset release, in microseconds.
    localparam int unsigned INIT_US = 2000;
    localparam int unsigned INIT_CYCLES = (INIT_US * 1000) / CLK_PERIOD_NS;
    // Width of the settings word restored to defaults by a full reset.
    localparam int unsigned SETTINGS_W = 8;
    localparam logic [SETTINGS_W-1:0] SETTINGS_RESET = 8'h00;
    // Position of the data-not-ready bit in the status byte.
    localparam int unsigned STATUS_DNR_BIT = 0;
    localparam int unsigned FAULT_W = 4;
    typedef enum logic [1:0] {
        MSR_RUN,
        MSR_HOLD,
        MSR_INIT
    } msr_state_t;
endpackage : msr_pkg

// >>> verification/msr_control_monitor.sv
// Port assertions for the select and reset control block.
module msr_control_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic module_select_pin_n,
    input wire logic module_select_pin_oe,
    input wire logic module_reset_pin_n,
    input wire logic module_reset_pin_oe,
    input wire logic bus_cmd_valid,
    input wire logic bus_cmd_accept,
    input wire logic bus_answer_en,
    input wire logic [7:0] settings,
    input wire logic [3:0] fault_event,
    input wire logic [3:0] fault_flags,
    input wire logic data_not_ready,
    input wire logic init_busy,
    input wire logic attention_out_n,
    input wire logic attention_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire sel = module_select_pin_oe && !module_select_pin_n;
    wire rlow = module_reset_pin_oe && !module_reset_pin_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    accept_gate_a: assert property (bus_cmd_accept == (bus_cmd_valid && sel)) else $error("accept wrong");
    desel_quiet_a: assert property (!sel |-> !bus_answer_en) else $error("answer while deselected");
    sel_answer_a: assert property (sel |-> bus_answer_en) else $error("no answer while selected");
    long_reset_a: assert property (rlow [*7] |=> init_busy && settings == 8'h00) else $error("no full reset");
    init_time_a: assert property (rlow [*7] ##1 !rlow |-> ##[12:20] $fell(init_busy)) else $error("init length");
    done_flag_a: assert property ($fell(init_busy) |-> !data_not_ready && attention_oe) else $error("no done");
    dnr_busy_a: assert property (data_not_ready == init_busy) else $error("not ready mismatch");
    power_up_a: assert property ($fell(rst) |-> ##[12:20] $fell(init_busy)) else $error("no power-up done");
    fault_att_a: assert property (|fault_event && !init_busy |=> attention_oe &&
        (fault_flags & $past(fault_event)) == $past(fault_event)) else $error("fault not flagged");
    od_level_a: assert property (attention_out_n == 1'b0) else $error("open-drain level high");
    cover property ($fell(init_busy));
    cover property (sel && bus_cmd_valid);
    cover property (|fault_event && !init_busy);
endmodule // msr_control_monitor
bind msr_control msr_control_monitor u_msr_control_monitor (.*);

// >>> verification/msr_control_test.sv
// Self-checking bench for the select and reset control block.
module msr_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, bus_cmd_valid = 1'b0, settings_we = 1'b0, flags_read = 1'b0, hold_reset = 1'b0;
    logic module_select_pin_n, module_select_pin_oe, module_reset_pin_n, module_reset_pin_oe, bus_cmd_accept;
    logic bus_answer_en, data_not_ready, init_busy, attention_out_n, attention_oe;
    logic [1:0] sel_mode = 2'h1;
    logic [7:0] settings_wdata = 8'h00, settings;
    logic [3:0] fault_event = 4'h0, fault_flags;
    int n_fail = 0, n_compared = 0, k;
    // Row: select mode, valid, expected accept, expected answer.
    logic [4:0] rows [6] = '{5'h00, 5'h04, 5'h09, 5'h0F, 5'h10, 5'h14};
    always #5 sys_clk = ~sys_clk;
    msr_host_model u_msr_host_model (.*);
    msr_control #(.RESET_MIN_CYCLES(4), .INIT_CYCLES(16)) u_msr_control (.*);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_done();
        k = 0;
        while (init_busy !== 1'b0 && k < 100) begin
            @(posedge sys_clk);
            #1 k++;
        end
        if (k == 100) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic drive(input logic [1:0] m, input logic we, input logic rd, input logic [3:0] ev, input int n);
        @(posedge sys_clk);
        sel_mode <= m;
        settings_we <= we;
        flags_read <= rd;
        fault_event <= ev;
        settings_wdata <= 8'hA5;
        repeat (n) @(posedge sys_clk);
        settings_we <= 1'b0;
        flags_read <= 1'b0;
        fault_event <= 4'h0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk("powerup busy", {7'h00, init_busy}, 8'h01);
        wait_done();
        chk("done flags", {6'h00, attention_oe, data_not_ready}, 8'h02);
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            sel_mode <= rows[i][4:3];
            bus_cmd_valid <= rows[i][2];
            #1 chk("bus gate", {6'h00, bus_cmd_accept, bus_answer_en}, {6'h00, rows[i][1:0]});
        end
        drive(2'h0, 1'b1, 1'b1, 4'h0, 1);
        chk("deselected ignored", {settings[6:0], attention_oe}, 8'h01);
        drive(2'h1, 1'b1, 1'b1, 4'h0, 1);
        chk("selected taken", {settings[6:0], attention_oe}, 8'h4A);
        drive(2'h1, 1'b0, 1'b0, 4'h2, 1);
        chk("fault flag", {3'h0, attention_oe, fault_flags}, 8'h12);
        drive(2'h1, 1'b0, 1'b1, 4'h0, 1);
        chk("flags cleared", {3'h0, attention_oe, fault_flags}, 8'h00);
        @(posedge sys_clk);
        hold_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        hold_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("short low kept", {settings[6:0], init_busy}, 8'h4A);
        @(posedge sys_clk);
        hold_reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        hold_reset <= 1'b0;
        #1 chk("long low reset", {settings[6:0], init_busy}, 8'h01);
        wait_done();
        chk("init from release", {7'h00, k inside {[16:18]}}, 8'h01);
        chk("reset done", {6'h00, attention_oe, data_not_ready}, 8'h02);
        summarize();
    end
endmodule // msr_control_test

// >>> verification/msr_host_model.sv
// Host board model that drives or releases the select and reset pins.
module msr_host_model (
    input wire logic [1:0] sel_mode,
    input wire logic hold_reset,
    output logic module_select_pin_n,
    output logic module_select_pin_oe,
    output logic module_reset_pin_n,
    output logic module_reset_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mode 0 releases the pin, so the line settles at the pull-up level, never the last value.
    assign module_select_pin_oe = sel_mode != 2'h0;
    assign module_select_pin_n = sel_mode != 2'h1;
    assign module_reset_pin_oe = hold_reset;
    assign module_reset_pin_n = !hold_reset;
endmodule // msr_host_model
